/* core/ccr_pkg.sv */
package ccr_pkg;
    // Clock and instruction cycle (four system clocks)
    localparam int CLK_PERIOD_NS   = 10;
    localparam int INSTR_PERIOD_NS = 40;
    localparam int INSTR_DIV       = (INSTR_PERIOD_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;

    // Register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int SEL_W  = 3;

    // Channel i: control a at 2*i, control b at 2*i+1
    localparam logic [ADDR_W-1:0] OFF_CTRL_A0  = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_CTRL_B0  = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_MIRROR   = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h9;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'hA;

    // comparator_control_a fields
    localparam int A_ON     = 7;
    localparam int A_RESULT = 6;
    localparam int A_INV    = 4;
    localparam int A_SPEED  = 2;
    localparam int A_HYS    = 1;
    localparam int A_SYNC   = 0;
    localparam logic [DATA_W-1:0] A_WR_MASK = 8'h97;
    localparam logic [DATA_W-1:0] A_RESET   = 8'h04;

    // comparator_control_b fields
    localparam int B_RISE     = 7;
    localparam int B_FALL     = 6;
    localparam int B_PSEL_LSB = 3;
    localparam int B_NSEL_LSB = 0;
    localparam logic [DATA_W-1:0] B_RESET = 8'h00;

    // Input select codes
    localparam logic [SEL_W-1:0] PSEL_GND  = 3'h7;
    localparam logic [SEL_W-1:0] PSEL_REF  = 3'h6;
    localparam logic [SEL_W-1:0] PSEL_DAC  = 3'h5;
    localparam logic [SEL_W-1:0] PSEL_PIN0 = 3'h0;
    localparam logic [SEL_W-1:0] NSEL_GND  = 3'h7;
    localparam logic [SEL_W-1:0] NSEL_REF  = 3'h6;
    localparam logic [SEL_W-1:0] NSEL_PIN3 = 3'h3;
    localparam logic [SEL_W-1:0] NSEL_PIN2 = 3'h2;
    localparam logic [SEL_W-1:0] NSEL_PIN1 = 3'h1;
    localparam logic [SEL_W-1:0] NSEL_PIN0 = 3'h0;
endpackage

/* core/ccr_channel.sv */
`timescale 1ns/1ps
module ccr_channel
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Timing
    input  wire logic              instr_tick_i,
    input  wire logic              tmr_fall_i,
    // Register writes
    input  wire logic              wr_a_i,
    input  wire logic              wr_b_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    // Analog comparison, 1 when non-inverting node is higher
    input  wire logic              raw_i,
    // State
    output logic      [DATA_W-1:0] ctrl_a_o,
    output logic      [DATA_W-1:0] ctrl_b_o,
    output logic                   result_o,
    output logic                   ext_o,
    output logic                   event_o
);
    logic [DATA_W-1:0] ctrl_a;
    logic              result;
    logic              result_d;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_a <= A_RESET;
        end else if (wr_a_i) begin
            ctrl_a <= wdata_i & A_WR_MASK;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_b_o <= B_RESET;
        end else if (wr_b_i) begin
            ctrl_b_o <= wdata_i;
        end
    end

    // Latched result
    // Disabled reads as 0 before polarity, so on/off and invert make edges
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            result <= 1'b0;
        end else if (instr_tick_i) begin
            result <= (ctrl_a[A_ON] & raw_i) ^ ctrl_a[A_INV];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            result_d <= 1'b0;
        end else begin
            result_d <= result;
        end
    end

    // Held between timer falling edges when synchronised
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_o <= 1'b0;
        end else if (!ctrl_a[A_SYNC] || tmr_fall_i) begin
            ext_o <= result;
        end
    end

    assign ctrl_a_o = {ctrl_a[7], result, ctrl_a[5:0]};
    assign result_o = result;
    assign event_o  = (ctrl_b_o[B_RISE] & result & ~result_d)
                    | (ctrl_b_o[B_FALL] & ~result & result_d);
endmodule

/* core/ccr_irq.sv */
`timescale 1ns/1ps
module ccr_irq
    import ccr_pkg::*;
#(
    parameter int N = 2
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Events and software access
    input  wire logic [N-1:0] set_i,
    input  wire logic         clr_wr_i,
    input  wire logic         mask_wr_i,
    input  wire logic [N-1:0] wdata_i,
    // State
    output logic      [N-1:0] status_o,
    output logic      [N-1:0] mask_o,
    output logic              irq_o
);
    logic [N-1:0] clr;

    assign clr = clr_wr_i ? wdata_i : '0;

    // A new event outranks a clear in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_o <= '0;
        end else begin
            status_o <= (status_o & ~clr) | set_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_o <= '0;
        end else if (mask_wr_i) begin
            mask_o <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_o & mask_o);
        end
    end
endmodule

/* core/ccr_top.sv */
`timescale 1ns/1ps
module ccr_top
    import ccr_pkg::*;
#(
    parameter int NUM_CMP   = 2,
    parameter bit LARGE_PKG = 1'b1
) (
    // Clock and reset
    input  wire logic                     CLOCK_I,
    input  wire logic                     RST_I,
    // Register port
    input  wire logic [ADDR_W-1:0]        ADDR_I,
    input  wire logic [DATA_W-1:0]        WDATA_I,
    input  wire logic                     WR_I,
    input  wire logic                     RD_I,
    output logic      [DATA_W-1:0]        RDATA_O,
    // Analog comparator side
    input  wire logic [NUM_CMP-1:0]       COMPARE_I,
    output logic      [NUM_CMP-1:0]       CMP_ENABLE_O,
    output logic      [NUM_CMP-1:0]       HYST_ENABLE_O,
    output logic      [NUM_CMP-1:0]       SPEED_HIGH_O,
    output logic      [SEL_W*NUM_CMP-1:0] POS_SEL_O,
    output logic      [NUM_CMP-1:0]       POS_CONNECT_O,
    output logic      [SEL_W*NUM_CMP-1:0] NEG_SEL_O,
    output logic      [NUM_CMP-1:0]       NEG_CONNECT_O,
    // Timer clock source, taken as synchronous
    input  wire logic                     TIMER_CLK_I,
    // Output to timer gate and pin
    output logic      [NUM_CMP-1:0]       CMP_OUT_O,
    // Interrupt
    output logic                          IRQ_O
);
    localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INSTR_DIV - 1);

    logic [DIV_W-1:0]   div_cnt;
    logic               instr_tick;
    logic               tmr_prev;
    logic               tmr_fall;
    logic [DATA_W-1:0]  ch_a      [NUM_CMP];
    logic [DATA_W-1:0]  ch_b      [NUM_CMP];
    logic [NUM_CMP-1:0] result;
    logic [NUM_CMP-1:0] ext;
    logic [NUM_CMP-1:0] evt;
    logic [NUM_CMP-1:0] wr_a;
    logic [NUM_CMP-1:0] wr_b;
    logic [NUM_CMP-1:0] irq_status;
    logic [NUM_CMP-1:0] irq_mask;
    logic               irq;
    logic [DATA_W-1:0]  next_rdata;
    logic [NUM_CMP-1:0] next_pos_conn;
    logic [NUM_CMP-1:0] next_neg_conn;

    // Instruction-cycle enable from the system clock
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            div_cnt <= '0;
        end else if (div_cnt == DIV_LAST) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    assign instr_tick = (div_cnt == DIV_LAST);

    // Timer clock falling edge, sampled on the system clock
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            tmr_prev <= 1'b0;
        end else begin
            tmr_prev <= TIMER_CLK_I;
        end
    end

    assign tmr_fall = tmr_prev & ~TIMER_CLK_I;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_ch
            assign wr_a[gi] = WR_I
                && (ADDR_I == ADDR_W'(OFF_CTRL_A0 + 2 * gi));
            assign wr_b[gi] = WR_I
                && (ADDR_I == ADDR_W'(OFF_CTRL_B0 + 2 * gi));

            ccr_channel u_ch (
                .clk_i        (CLOCK_I),
                .rst_i        (RST_I),
                .instr_tick_i (instr_tick),
                .tmr_fall_i   (tmr_fall),
                .wr_a_i       (wr_a[gi]),
                .wr_b_i       (wr_b[gi]),
                .wdata_i      (WDATA_I),
                .raw_i        (COMPARE_I[gi]),
                .ctrl_a_o     (ch_a[gi]),
                .ctrl_b_o     (ch_b[gi]),
                .result_o     (result[gi]),
                .ext_o        (ext[gi]),
                .event_o      (evt[gi])
            );
        end
    endgenerate

    // Sticky flags, write one to clear
    ccr_irq #(
        .N (NUM_CMP)
    ) u_irq (
        .clk_i     (CLOCK_I),
        .rst_i     (RST_I),
        .set_i     (evt),
        .clr_wr_i  (WR_I && (ADDR_I == OFF_IRQ_STAT)),
        .mask_wr_i (WR_I && (ADDR_I == OFF_IRQ_MASK)),
        .wdata_i   (WDATA_I[NUM_CMP-1:0]),
        .status_o  (irq_status),
        .mask_o    (irq_mask),
        .irq_o     (irq)
    );

    assign IRQ_O = irq;

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        for (int i = 0; i < NUM_CMP; i++) begin
            if (ADDR_I == ADDR_W'(OFF_CTRL_A0 + 2 * i)) begin
                next_rdata = ch_a[i];
            end
            if (ADDR_I == ADDR_W'(OFF_CTRL_B0 + 2 * i)) begin
                next_rdata = ch_b[i];
            end
        end
        if (ADDR_I == OFF_MIRROR) begin
            next_rdata[NUM_CMP-1:0] = result;
        end
        if (ADDR_I == OFF_IRQ_STAT) begin
            next_rdata[NUM_CMP-1:0] = irq_status;
        end
        if (ADDR_I == OFF_IRQ_MASK) begin
            next_rdata[NUM_CMP-1:0] = irq_mask;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            RDATA_O <= '0;
        end else if (RD_I) begin
            RDATA_O <= next_rdata;
        end else begin
            RDATA_O <= '0;
        end
    end

    // Input routing; a disabled comparator connects nothing
    always_comb begin
        next_pos_conn = '0;
        next_neg_conn = '0;
        for (int i = 0; i < NUM_CMP; i++) begin
            case (ch_b[i][B_PSEL_LSB +: SEL_W])
                PSEL_GND, PSEL_REF, PSEL_DAC, PSEL_PIN0:
                    next_pos_conn[i] = ch_a[i][A_ON];
                default:
                    next_pos_conn[i] = 1'b0;
            endcase
            case (ch_b[i][B_NSEL_LSB +: SEL_W])
                NSEL_GND, NSEL_REF, NSEL_PIN1, NSEL_PIN0:
                    next_neg_conn[i] = ch_a[i][A_ON];
                NSEL_PIN3, NSEL_PIN2:
                    next_neg_conn[i] = ch_a[i][A_ON] & LARGE_PKG;
                default:
                    next_neg_conn[i] = 1'b0;
            endcase
        end
    end

    // Analog controls registered so the pins never glitch
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            CMP_ENABLE_O  <= '0;
            HYST_ENABLE_O <= '0;
            SPEED_HIGH_O  <= '1;
            POS_SEL_O     <= '0;
            NEG_SEL_O     <= '0;
            POS_CONNECT_O <= '0;
            NEG_CONNECT_O <= '0;
        end else begin
            for (int i = 0; i < NUM_CMP; i++) begin
                CMP_ENABLE_O[i]  <= ch_a[i][A_ON];
                HYST_ENABLE_O[i] <= ch_a[i][A_HYS];
                SPEED_HIGH_O[i]  <= ch_a[i][A_SPEED];
                POS_SEL_O[i*SEL_W +: SEL_W] <=
                    ch_b[i][B_PSEL_LSB +: SEL_W];
                NEG_SEL_O[i*SEL_W +: SEL_W] <=
                    ch_b[i][B_NSEL_LSB +: SEL_W];
            end
            POS_CONNECT_O <= next_pos_conn;
            NEG_CONNECT_O <= next_neg_conn;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            CMP_OUT_O <= '0;
        end else begin
            CMP_OUT_O <= ext;
        end
    end

    // Assertions
    a_enable_drive: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        wr_a[0] |-> ##2 CMP_ENABLE_O[0] == $past(WDATA_I[A_ON], 2))
        else $error("enable output does not follow written bit");

    a_result_pol: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        instr_tick |=> result[0] == ((ch_a[0][A_ON] && $past(COMPARE_I[0]))
            ^ ch_a[0][A_INV]) || $past(wr_a[0]))
        else $error("result bit wrong for inputs and polarity");

    a_result_hold: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        !instr_tick |=> $stable(result))
        else $error("result changed outside instruction cycle");

    a_rise_flag: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        $rose(result[0]) && ch_b[0][B_RISE] |=> irq_status[0])
        else $error("rising edge did not set flag");

    a_fall_quiet: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        $fell(result[0]) && !ch_b[0][B_FALL] && !irq_status[0]
            |=> !irq_status[0])
        else $error("masked falling edge set flag");

    a_set_wins: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        evt[0] && WR_I && ADDR_I == OFF_IRQ_STAT && WDATA_I[0]
            |=> irq_status[0])
        else $error("clear beat a concurrent edge");

    a_sync_hold: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        ch_a[0][A_SYNC] && !tmr_fall && !wr_a[0]
            |=> ##1 $stable(CMP_OUT_O[0]))
        else $error("synchronised output moved without timer edge");

    a_async_pass: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        !ch_a[0][A_SYNC] |=> ##1 CMP_OUT_O[0] == $past(result[0], 2))
        else $error("asynchronous output does not follow result");

    a_mirror_read: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        RD_I && ADDR_I == OFF_MIRROR
            |=> RDATA_O == DATA_W'($past(result)))
        else $error("mirror read wrong");

    a_unimpl_zero: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        RD_I && ADDR_I == OFF_CTRL_A0 |=> !RDATA_O[5] && !RDATA_O[3])
        else $error("unimplemented bits read nonzero");

    a_neg_small: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        ch_b[0][B_NSEL_LSB +: SEL_W] == NSEL_PIN3
            |=> NEG_CONNECT_O[0] == (LARGE_PKG && $past(ch_a[0][A_ON])))
        else $error("pin 3 connection wrong for variant");

    a_pol_edge: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        !ch_a[0][A_ON] && instr_tick && result[0] != ch_a[0][A_INV]
            |=> $changed(result[0]))
        else $error("polarity toggle gave no result edge");

    a_hyst_drive: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        wr_a[0] |-> ##2 HYST_ENABLE_O[0] == $past(WDATA_I[A_HYS], 2))
        else $error("hysteresis output does not follow written bit");

    a_speed_drive: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        wr_a[0] |-> ##2 SPEED_HIGH_O[0] == $past(WDATA_I[A_SPEED], 2))
        else $error("speed output does not follow written bit");

    a_rise_quiet: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        $rose(result[0]) && !ch_b[0][B_RISE] && !irq_status[0]
            |=> !irq_status[0])
        else $error("masked rising edge set flag");

    a_irq_level: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        1'b1 |=> IRQ_O == (|$past(irq_status & irq_mask)))
        else $error("interrupt output does not follow flags");

    a_rdata_idle: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        !RD_I |=> RDATA_O == '0)
        else $error("read data not zero outside read cycle");

    c_rise_irq: cover property (
        @(posedge CLOCK_I) disable iff (RST_I)
        $rose(irq_status[0]) ##[1:20] IRQ_O);

    c_sync_update: cover property (
        @(posedge CLOCK_I) disable iff (RST_I)
        ch_a[0][A_SYNC] && tmr_fall ##2 $changed(CMP_OUT_O[0]));

    c_clear_flag: cover property (
        @(posedge CLOCK_I) disable iff (RST_I)
        irq_status[0] ##1 !irq_status[0]);

    c_race_set: cover property (
        @(posedge CLOCK_I) disable iff (RST_I)
        evt[0] && WR_I && ADDR_I == OFF_IRQ_STAT ##1 irq_status[0]);

    c_pol_toggle: cover property (
        @(posedge CLOCK_I) disable iff (RST_I)
        !ch_a[0][A_ON] && $changed(result[0]));
endmodule

/* tb/ccr_top_tb.sv */
`timescale 1ns/1ps
module ccr_top_tb
    import ccr_pkg::*;
;
    localparam logic [ADDR_W-1:0] off_a1 = 4'h2;
    localparam logic [ADDR_W-1:0] off_b1 = 4'h3;

    logic                clock_i = 1'b0;
    logic                rst_i   = 1'b1;
    logic [ADDR_W-1:0]   addr    = 4'h0;
    logic [DATA_W-1:0]   wdata   = 8'h00;
    logic                wr      = 1'b0;
    logic                rd      = 1'b0;
    logic [DATA_W-1:0]   rdata;
    logic [1:0]          cmp     = 2'h0;
    logic                tmr_clk = 1'b1;
    logic [1:0]          cmp_en;
    logic [1:0]          hyst;
    logic [1:0]          speed;
    logic [5:0]          pos_sel;
    logic [1:0]          pos_con;
    logic [5:0]          neg_sel;
    logic [1:0]          neg_con;
    logic [1:0]          cmp_out;
    logic                irq;
    int                  n_mismatch  = 0;
    int                  comparisons = 0;
    int                  cyc         = 0;

    always #5 clock_i = ~clock_i;

    // Edges since reset release; a result latch edge reads cyc ending in 3
    always @(posedge clock_i) begin
        cyc <= rst_i ? 0 : cyc + 1;
    end

    ccr_top #(
        .NUM_CMP   (2),
        .LARGE_PKG (1'b1)
    ) ccr_top_i (
        .CLOCK_I       (clock_i),
        .RST_I         (rst_i),
        .ADDR_I        (addr),
        .WDATA_I       (wdata),
        .WR_I          (wr),
        .RD_I          (rd),
        .RDATA_O       (rdata),
        .COMPARE_I     (cmp),
        .CMP_ENABLE_O  (cmp_en),
        .HYST_ENABLE_O (hyst),
        .SPEED_HIGH_O  (speed),
        .POS_SEL_O     (pos_sel),
        .POS_CONNECT_O (pos_con),
        .NEG_SEL_O     (neg_sel),
        .NEG_CONNECT_O (neg_con),
        .TIMER_CLK_I   (tmr_clk),
        .CMP_OUT_O     (cmp_out),
        .IRQ_O         (irq)
    );

    task automatic results();
        $display("Counts: %0d mismatches, %0d comparisons", n_mismatch,
                 comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A gap cycle follows every strobe, so no strobe is driven twice at once
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_i);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_i);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // Covers the instruction tick, result latch and the output registers
    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic set_cmp(input logic [1:0] v);
        @(posedge clock_i);
        cmp <= v;
        settle(10);
    endtask

    task automatic t_reset();
        rd_chk(OFF_CTRL_A0, A_RESET);
        rd_chk(OFF_CTRL_B0, B_RESET);
        rd_chk(off_a1, A_RESET);
        rd_chk(off_b1, B_RESET);
        rd_chk(OFF_MIRROR, 8'h00);
        chk({6'h0, speed}, 8'h03);
        chk({6'h0, cmp_en}, 8'h00);
    endtask

    task automatic t_ctrl_a();
        wr_reg(OFF_CTRL_A0, 8'hEF);
        rd_chk(OFF_CTRL_A0, 8'h87);
        settle(2);
        chk({2'h0, cmp_en, hyst, speed}, 8'h17);
        wr_reg(OFF_CTRL_A0, 8'h04);
        settle(2);
        chk({4'h0, cmp_en, hyst}, 8'h00);
        rd_chk(4'hF, 8'h00);
        wr_reg(4'hB, 8'hFF);
        rd_chk(4'hB, 8'h00);
    endtask

    task automatic t_result();
        wr_reg(OFF_CTRL_A0, 8'h84);
        wr_reg(off_a1, 8'h94);
        set_cmp(2'b01);
        rd_chk(OFF_CTRL_A0, 8'hC4);
        rd_chk(off_a1, 8'hD4);
        rd_chk(OFF_MIRROR, 8'h03);
        set_cmp(2'b10);
        rd_chk(OFF_CTRL_A0, 8'h84);
        rd_chk(off_a1, 8'h94);
        rd_chk(OFF_MIRROR, 8'h00);
        wr_reg(OFF_CTRL_B0, 8'h2A);
        rd_chk(off_b1, 8'h00);
        rd_chk(OFF_CTRL_B0, 8'h2A);
        wr_reg(off_a1, 8'h04);
        set_cmp(2'b00);
    endtask

    task automatic t_select();
        logic [2:0] c;
        logic       pe;
        logic       ne;
        wr_reg(OFF_CTRL_A0, 8'h84);
        for (int i = 0; i < 8; i++) begin
            c  = i[2:0];
            pe = (c == PSEL_GND || c == PSEL_REF || c == PSEL_DAC ||
                  c == PSEL_PIN0);
            ne = (c != 3'h4 && c != 3'h5);
            wr_reg(OFF_CTRL_B0, {2'b00, c, c});
            settle(2);
            chk({2'h0, pos_sel[2:0], neg_sel[2:0]}, {2'h0, c, c});
            chk({6'h0, pos_con[0], neg_con[0]}, {6'h0, pe, ne});
        end
        wr_reg(OFF_CTRL_B0, {2'b00, PSEL_GND, NSEL_PIN3});
        wr_reg(OFF_CTRL_A0, 8'h04);
        settle(2);
        chk({6'h0, pos_con[0], neg_con[0]}, 8'h00);
        wr_reg(OFF_CTRL_A0, 8'h84);
        settle(2);
        chk({6'h0, pos_con[0], neg_con[0]}, 8'h03);
    endtask

    task automatic t_irq();
        wr_reg(OFF_CTRL_B0, 8'h80);
        wr_reg(OFF_IRQ_MASK, 8'h01);
        rd_chk(OFF_IRQ_MASK, 8'h01);
        rd_chk(OFF_IRQ_STAT, 8'h00);
        set_cmp(2'b01);
        rd_chk(OFF_IRQ_STAT, 8'h01);
        chk({7'h0, irq}, 8'h01);
        wr_reg(OFF_IRQ_STAT, 8'h01);
        settle(2);
        rd_chk(OFF_IRQ_STAT, 8'h00);
        chk({7'h0, irq}, 8'h00);
        set_cmp(2'b00);
        rd_chk(OFF_IRQ_STAT, 8'h00);
        wr_reg(OFF_CTRL_B0, 8'h40);
        set_cmp(2'b01);
        rd_chk(OFF_IRQ_STAT, 8'h00);
        set_cmp(2'b00);
        rd_chk(OFF_IRQ_STAT, 8'h01);
        wr_reg(OFF_IRQ_STAT, 8'h01);
        wr_reg(OFF_IRQ_MASK, 8'h00);
        wr_reg(OFF_CTRL_B0, 8'hC0);
        set_cmp(2'b01);
        rd_chk(OFF_IRQ_STAT, 8'h01);
        chk({7'h0, irq}, 8'h00);
        wr_reg(OFF_IRQ_STAT, 8'h01);
        wr_reg(OFF_IRQ_MASK, 8'h01);
        set_cmp(2'b00);
        wr_reg(OFF_IRQ_STAT, 8'h01);
        wr_reg(OFF_CTRL_A0, 8'h04);
        wr_reg(OFF_CTRL_A0, 8'h14);
        settle(10);
        rd_chk(OFF_IRQ_STAT, 8'h01);
        wr_reg(OFF_IRQ_STAT, 8'h01);
        wr_reg(OFF_CTRL_A0, 8'h04);
        settle(10);
        rd_chk(OFF_IRQ_STAT, 8'h01);
        wr_reg(OFF_IRQ_STAT, 8'h01);
        wr_reg(OFF_CTRL_B0, 8'h00);
    endtask

    // Clear write lands on the edge that samples a new rise event
    task automatic t_race();
        wr_reg(OFF_CTRL_A0, 8'h84);
        wr_reg(OFF_CTRL_B0, 8'h80);
        @(posedge clock_i);
        for (int k = 0; k < 4 && cyc[1:0] != 2'h2; k++) begin
            @(posedge clock_i);
        end
        if (cyc[1:0] != 2'h2) begin
            n_mismatch++;
        end
        cmp   <= 2'b01;
        @(posedge clock_i);
        addr  <= OFF_IRQ_STAT;
        wdata <= 8'h01;
        wr    <= 1'b1;
        @(posedge clock_i);
        wr    <= 1'b0;
        settle(2);
        rd_chk(OFF_IRQ_STAT, 8'h01);
        wr_reg(OFF_IRQ_STAT, 8'h01);
        set_cmp(2'b00);
        rd_chk(OFF_IRQ_STAT, 8'h00);
        wr_reg(OFF_CTRL_B0, 8'h00);
    endtask

    task automatic t_sync();
        wr_reg(OFF_CTRL_A0, 8'h84);
        set_cmp(2'b01);
        chk({7'h0, cmp_out[0]}, 8'h01);
        wr_reg(OFF_CTRL_A0, 8'h85);
        set_cmp(2'b00);
        chk({7'h0, cmp_out[0]}, 8'h01);
        @(posedge clock_i);
        tmr_clk <= 1'b0;
        settle(4);
        chk({7'h0, cmp_out[0]}, 8'h00);
        @(posedge clock_i);
        tmr_clk <= 1'b1;
    endtask

    // Cuts a hang short; every scenario fits well inside this
    initial begin
        repeat (20000) @(posedge clock_i);
        n_mismatch++;
        results();
    end

    initial begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        settle(1);
        t_reset();
        t_ctrl_a();
        t_result();
        t_select();
        t_irq();
        t_race();
        t_sync();
        results();
    end
endmodule
